// ===== dbt_sequencer.sv
// Behaviour
// [RULE1] Drive function codes use fixed octal encoding
// [RULE2] Write-check codes behave as read codes
// [RULE3] Control word: negative count, address minus one
// [RULE4] Termination word stored after initial location
// [RULE5] Two 18-bit halves make one word
// [RULE6] Armed flag gives end-of-block pulse at start
// [RULE7] Load with data function starts channel list
// [RULE8] Continue_to_disk_end continues through block ends to end of disk
// [RULE9] Recycle restarts the same operation forever
// [RULE10] Held function code shown on indicators
// [RULE11] Drive select field and load bit
// [RULE12] Maintenance mode makes data clock internally
`timescale 1ns/1ps
`default_nettype none
`include "dbt_defines.svh"

module dbt_sequencer (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Memory channel
    output var dbt_pkg::dbt_mem_req_s mem_req,
    input  wire logic          mem_ack,
    input  wire logic [35:0]   mem_rdata,
    // Drive control
    output var dbt_pkg::dbt_drv_cmd_s drv_cmd,
    output logic               end_of_block_pulse,
    output logic [5:0]         function_indicator,
    output logic               busy,
    output logic               done,
    input  wire logic          drive_sclk,
    input  wire logic          drv_block_end,
    input  wire logic          drv_disk_end,
    // Drive data, drive to memory
    input  wire logic          drv_rd_valid,
    input  wire logic [35:0]   drv_rd_data,
    output logic               drv_rd_ready,
    // Drive data, memory to drive
    output logic               drv_wr_valid,
    output logic [35:0]        drv_wr_data,
    input  wire logic          drv_wr_ready
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    dbt_pkg::dbt_seq_s s;
    dbt_pkg::dbt_seq_s next_s;
    logic        setup;
    logic        wr_acc;
    logic        hit;
    logic        db_hit;
    logic        rd_dir;
    logic        strobe;
    logic        asm_push;
    logic        ack_push;
    logic        drv_push;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [35:0] f_in_data;
    logic        f_out_valid;
    logic        f_out_ready;
    logic [35:0] f_out_data;
    logic        start;
    logic [31:0] rmux;

    // Read-direction functions
    function automatic logic is_rd(input logic [5:0] f);
        is_rd = (f == `DBT_FN_READ) | (f == `DBT_FN_READ_HD)    // see [RULE1]
              | (f == `DBT_FN_WCHK) | (f == `DBT_FN_WCHK_HD);   // see [RULE2]
    endfunction

    // Write-direction functions
    function automatic logic is_wr(input logic [5:0] f);
        is_wr = (f == `DBT_FN_WRITE) | (f == `DBT_FN_WRITE_HD); // see [RULE1]
    endfunction

    // ----------------------------------------
    // Bus decode and data path steering
    // ----------------------------------------
    assign setup  = psel & ~penable;
    assign hit    = (paddr == `DBT_CMD_OFS) | (paddr == `DBT_INITIAL_CONTROL_WORD_ADDRESS_OFS)
                  | (paddr == `DBT_DB_OFS) | (paddr == `DBT_STAT_OFS)
                  | (paddr == `DBT_TERML_OFS) | (paddr == `DBT_TERMR_OFS);
    assign db_hit = (paddr == `DBT_DB_OFS);
    assign rd_dir = is_rd(s.fn);
    assign strobe = s.maint ? s.tick : drive_sclk;              // see [RULE12]

    // Second half stalls while the buffer cannot take a word or a write-direction transfer is busy
    assign pready  = ~(psel & penable & pwrite & db_hit & s.half_full
                     & ~(f_in_ready & (rd_dir | ~s.busy)));
    assign pslverr = psel & penable & ~hit;
    assign prdata  = s.prdata;
    assign wr_acc  = psel & penable & pwrite & pready & hit;

    // Buffer fill sources
    assign asm_push     = wr_acc & db_hit & s.half_full;        // see [RULE5]
    assign ack_push     = mem_ack & (s.st == dbt_pkg::DBT_XFER) & ~s.mreq.we;
    assign drv_rd_ready = s.busy & rd_dir & strobe & f_in_ready & ~asm_push;
    assign drv_push     = drv_rd_ready & drv_rd_valid;
    assign f_in_valid   = asm_push | ack_push | drv_push;

    // Fill data selection
    always_comb
    begin
        if (asm_push)
            f_in_data = {s.half, pwdata[17:0]};                 // see [RULE5]
        else if (ack_push)
            f_in_data = mem_rdata;
        else
            f_in_data = drv_rd_data;
    end

    // Buffer drain to memory or drive
    assign drv_wr_valid = s.busy & ~rd_dir & f_out_valid & strobe;
    assign drv_wr_data  = f_out_data;
    assign f_out_ready  = rd_dir ? (mem_ack & (s.st == dbt_pkg::DBT_XFER) & s.mreq.we)
                                 : (drv_wr_valid & drv_wr_ready);

    // Outputs
    assign mem_req            = s.mreq;
    assign drv_cmd            = '{fn: s.fn, sel: s.sel, go: s.go};
    assign end_of_block_pulse = s.eob_p;
    assign function_indicator = s.fn;                           // see [RULE10]
    assign busy               = s.busy;
    assign done               = s.done;

    // Start of a channel transfer
    assign start = wr_acc & (paddr == `DBT_CMD_OFS) & ~s.busy
                 & pwdata[`DBT_CMD_LOAD] & pwdata[`DBT_CMD_CHEN]
                 & (is_rd(pwdata[5:0]) | is_wr(pwdata[5:0]));   // see [RULE7]

    // Register read selection
    always_comb
    begin
        rmux = 32'h0000_0000;
        if (paddr == `DBT_CMD_OFS)
            rmux = {18'h00000, s.chen, s.maint, s.recyc, s.multi, s.sel, 1'b0, s.fn};
        else if (paddr == `DBT_INITIAL_CONTROL_WORD_ADDRESS_OFS)
            rmux = {14'h0000, s.initial_control_word_address};
        else if (paddr == `DBT_DB_OFS)
            rmux = {13'h0000, s.eob_arm, s.half};
        else if (paddr == `DBT_STAT_OFS)
            rmux = {27'h0000000, s.stop, s.half_full, f_out_valid, s.done, s.busy};
        else if (paddr == `DBT_TERML_OFS)
            rmux = {14'h0000, s.term[35:18]};
        else if (paddr == `DBT_TERMR_OFS)
            rmux = {14'h0000, s.term[17:0]};
    end

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb
    begin
        next_s       = s;
        next_s.go    = 1'b0;
        next_s.eob_p = 1'b0;
        next_s.tick  = 1'b0;

        // Maintenance data clock divider
        if (s.div == 4'(`DBT_MSCLK_CYC - 1))
        begin
            next_s.div  = 4'h0;
            next_s.tick = 1'b1;                                 // see [RULE12]
        end
        else
            next_s.div = s.div + 4'h1;

        // Read data captured in the setup cycle
        if (setup)
            next_s.prdata = rmux;

        // Register writes
        if (wr_acc & (paddr == `DBT_CMD_OFS) & ~s.busy)
        begin
            next_s.fn    = pwdata[`DBT_CMD_FN_LSB +: 6];
            next_s.sel   = pwdata[`DBT_CMD_SEL_LSB +: 3];       // see [RULE11]
            next_s.multi = pwdata[`DBT_CMD_MULTI];
            next_s.recyc = pwdata[`DBT_CMD_RECYC];
            next_s.maint = pwdata[`DBT_CMD_MAINT];
            next_s.chen  = pwdata[`DBT_CMD_CHEN];
            if (pwdata[`DBT_CMD_LOAD])
            begin
                next_s.go      = 1'b1;                          // see [RULE11]
                next_s.eob_p   = s.eob_arm;                     // see [RULE6]
                next_s.eob_arm = 1'b0;
            end
        end
        if (wr_acc & (paddr == `DBT_INITIAL_CONTROL_WORD_ADDRESS_OFS) & ~s.busy)
            next_s.initial_control_word_address = pwdata[17:0];
        if (wr_acc & db_hit)
        begin
            next_s.half_full = ~s.half_full;                    // see [RULE5]
            if (~s.half_full)
                next_s.half = pwdata[17:0];
            if (pwdata[`DBT_DB_EOB])
                next_s.eob_arm = 1'b1;                          // see [RULE6]
        end

        // Channel start
        if (start)
        begin
            next_s.st   = dbt_pkg::DBT_FETCH;                   // see [RULE7]
            next_s.cw   = s.initial_control_word_address;
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.stop = 1'b0;
        end

        case (s.st)
            dbt_pkg::DBT_FETCH:
            begin
                if (~s.mreq.req)
                begin
                    if (s.stop)
                        next_s.st = dbt_pkg::DBT_TERM;
                    else
                        next_s.mreq = '{req: 1'b1, we: 1'b0, addr: s.cw,
                                        wdata: 36'h0_0000_0000};
                end
                else if (mem_ack)
                begin
                    next_s.mreq.req = 1'b0;
                    if (mem_rdata == 36'h0_0000_0000)
                        next_s.st = dbt_pkg::DBT_TERM;
                    else if (mem_rdata[35:18] == 18'h00000)
                        next_s.cw = mem_rdata[17:0];
                    else
                    begin
                        next_s.cnt     = mem_rdata[35:18];          // see [RULE3]
                        next_s.daddr   = mem_rdata[17:0] + 18'h00001; // see [RULE3]
                        next_s.last_cw = s.cw;
                        next_s.st      = dbt_pkg::DBT_XFER;
                    end
                end
            end
            dbt_pkg::DBT_XFER:
            begin
                if (s.mreq.req)
                begin
                    if (mem_ack)
                    begin
                        next_s.mreq.req  = 1'b0;
                        next_s.last_addr = s.daddr;
                        next_s.daddr     = s.daddr + 18'h00001;
                        next_s.cnt       = s.cnt + 18'h00001;   // see [RULE3]
                        if (s.cnt == 18'h3FFFF)
                        begin
                            next_s.cw = s.cw + 18'h00001;
                            next_s.st = dbt_pkg::DBT_FETCH;
                        end
                    end
                end
                else if (rd_dir & f_out_valid)
                    next_s.mreq = '{req: 1'b1, we: 1'b1, addr: s.daddr,
                                    wdata: f_out_data};
                else if (s.stop)
                    next_s.st = dbt_pkg::DBT_TERM;
                else if (~rd_dir & f_in_ready)
                    next_s.mreq = '{req: 1'b1, we: 1'b0, addr: s.daddr,
                                    wdata: 36'h0_0000_0000};
            end
            dbt_pkg::DBT_TERM:
            begin
                // Write data reaches the drive before the final word
                if (~s.mreq.req & (rd_dir | ~f_out_valid))
                    next_s.mreq = '{req: 1'b1, we: 1'b1,
                                    addr: s.initial_control_word_address + 18'h00001,           // see [RULE4]
                                    wdata: {s.last_cw + 18'h00001, s.last_addr}};
                else if (mem_ack)
                begin
                    next_s.mreq.req = 1'b0;
                    next_s.term     = s.mreq.wdata;             // see [RULE4]
                    next_s.stop     = 1'b0;
                    if (s.recyc)
                    begin
                        next_s.cw = s.initial_control_word_address;                     // see [RULE9]
                        next_s.go = 1'b1;
                        next_s.st = dbt_pkg::DBT_FETCH;
                    end
                    else
                    begin
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                        next_s.st   = dbt_pkg::DBT_IDLE;
                    end
                end
            end
            default:
            begin
                next_s.st = start ? dbt_pkg::DBT_FETCH : dbt_pkg::DBT_IDLE;
            end
        endcase

        // End of transfer requests; set wins over clear
        if (s.busy & (drv_disk_end | (drv_block_end & ~s.multi)))
            next_s.stop = 1'b1;                                 // see [RULE8]
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s      <= '0;
            s.st   <= dbt_pkg::DBT_IDLE;
            s.fn   <= `DBT_FN_RST;
            s.initial_control_word_address <= `DBT_ADDR_RST;
        end
        else
            s <= next_s;
    end

    // ----------------------------------------
    // Data buffer between drive and memory
    // ----------------------------------------
    dbt_fifo #(
        .W (36),
        .D (16)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (start),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

endmodule

`default_nettype wire

// ===== dbt_defines.svh
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DBT_CMD_OFS      12'h000
`define DBT_INITIAL_CONTROL_WORD_ADDRESS_OFS     12'h004
`define DBT_DB_OFS       12'h008
`define DBT_STAT_OFS     12'h00C
`define DBT_TERML_OFS    12'h010
`define DBT_TERMR_OFS    12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DBT_CMD_FN_LSB   0
`define DBT_CMD_LOAD     6
`define DBT_CMD_SEL_LSB  7
`define DBT_CMD_MULTI    10
`define DBT_CMD_RECYC    11
`define DBT_CMD_MAINT    12
`define DBT_CMD_CHEN     13
`define DBT_DB_EOB       18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DBT_FN_RST       6'h00
`define DBT_ADDR_RST     18'h00000

// ----------------------------------------
// Drive function codes
// ----------------------------------------
`define DBT_FN_NOP       6'h01
`define DBT_FN_UNLOAD    6'h03
`define DBT_FN_SEEK      6'h05
`define DBT_FN_RECAL     6'h07
`define DBT_FN_DCLR      6'h09
`define DBT_FN_RELEASE   6'h0B
`define DBT_FN_OFFSET    6'h0D
`define DBT_FN_CENTRE    6'h0F
`define DBT_FN_PRESET    6'h11
`define DBT_FN_PACKACK   6'h13
`define DBT_FN_SEARCH    6'h19
`define DBT_FN_WCHK      6'h29
`define DBT_FN_WCHK_HD   6'h2B
`define DBT_FN_WRITE     6'h31
`define DBT_FN_WRITE_HD  6'h33
`define DBT_FN_READ      6'h39
`define DBT_FN_READ_HD   6'h3B

// ----------------------------------------
// Timing
// ----------------------------------------
`define DBT_CLK_NS       40
`define DBT_MSCLK_NS     400
`define DBT_MSCLK_CYC    ((`DBT_MSCLK_NS + `DBT_CLK_NS - 1) / `DBT_CLK_NS)

`endif

// ===== dbt_pkg.sv
package dbt_pkg;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [3:0] {
        DBT_IDLE  = 4'b0001,
        DBT_FETCH = 4'b0010,
        DBT_XFER  = 4'b0100,
        DBT_TERM  = 4'b1000
    } dbt_state_e;

    // ----------------------------------------
    // Memory channel request
    // ----------------------------------------
    typedef struct packed {
        logic        req;
        logic        we;
        logic [17:0] addr;
        logic [35:0] wdata;
    } dbt_mem_req_s;

    // ----------------------------------------
    // Drive command outputs
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] fn;
        logic [2:0] sel;
        logic       go;
    } dbt_drv_cmd_s;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    typedef struct packed {
        dbt_state_e   st;
        logic [5:0]   fn;
        logic [2:0]   sel;
        logic         multi;
        logic         recyc;
        logic         maint;
        logic         chen;
        logic [17:0]  initial_control_word_address;
        logic [17:0]  cw;
        logic [17:0]  last_cw;
        logic [17:0]  cnt;
        logic [17:0]  daddr;
        logic [17:0]  last_addr;
        logic [17:0]  half;
        logic         half_full;
        logic         eob_arm;
        logic         eob_p;
        logic         go;
        logic         busy;
        logic         done;
        logic         stop;
        logic [35:0]  term;
        logic [31:0]  prdata;
        dbt_mem_req_s mreq;
        logic [3:0]   div;
        logic         tick;
    } dbt_seq_s;

endpackage

// ===== dbt_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module dbt_fifo #(
    parameter int W  = 36,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clear,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } dbt_fifo_s;

    dbt_fifo_s s;
    dbt_fifo_s next_s;
    logic      push;
    logic      pop;

    // Honest full and empty
    assign in_ready  = (s.cnt != (AW+1)'(D));
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update
    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop)
            next_s.rp = s.rp + 1'b1;
        if (push & ~pop)
            next_s.cnt = s.cnt + 1'b1;
        else if (pop & ~push)
            next_s.cnt = s.cnt - 1'b1;
        if (clear)
        begin
            next_s.wp  = '0;
            next_s.rp  = '0;
            next_s.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= next_s;
    end

endmodule

`default_nettype wire

// ===== dbt_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the sequencer
// ----------------------------------------
module dbt_sequencer_props (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Register bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Channel and drive
    input var dbt_pkg::dbt_mem_req_s  mem_req,
    input wire logic                  mem_ack,
    input var dbt_pkg::dbt_drv_cmd_s  drv_cmd,
    input wire logic                  end_of_block_pulse,
    input wire logic [5:0]            function_indicator,
    input wire logic                  busy,
    input wire logic                  done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accepted command load while idle
    sequence s_load;
        psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[6] && !busy;
    endsequence
    // Load that starts a channel read
    sequence s_rd_start;
        s_load ##0 (pwdata[13] && pwdata[5:0] == 6'h39);
    endsequence
    a_load_go: assert property (s_load |=> drv_cmd.go)
        else $error("no go after load");
    a_go_code: assert property (s_load |=> drv_cmd.fn == $past(pwdata[5:0])
        && drv_cmd.sel == $past(pwdata[9:7]))
        else $error("go code or select wrong");
    a_go_single: assert property (drv_cmd.go |=> !drv_cmd.go)
        else $error("go too long");
    a_ind_code: assert property (drv_cmd.go
        |-> ##[0:1] function_indicator == drv_cmd.fn)
        else $error("indicator wrong");
    a_eob_start: assert property (end_of_block_pulse |-> drv_cmd.go)
        else $error("eob outside start");
    a_bad_addr: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("unmapped without error");
    a_req_hold: assert property (mem_req.req && !mem_ack
        |=> mem_req.req && $stable(mem_req))
        else $error("request changed before ack");
    a_start_busy: assert property (s_rd_start |=> busy && !done)
        else $error("start left busy low");
    a_done_idle: assert property ($rose(done) |-> !busy)
        else $error("done while busy");
endmodule

bind dbt_sequencer dbt_sequencer_props u_props (.*);
`default_nettype wire

// ===== dbt_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Drive side model
// ----------------------------------------
module dbt_drive_model (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Controls
    input  wire logic                 src_en,
    input  var dbt_pkg::dbt_drv_cmd_s drv_cmd,
    // Drive to controller
    output logic                      drv_rd_valid,
    output logic [35:0]               drv_rd_data,
    input  wire logic                 drv_rd_ready,
    // Controller to drive
    input  wire logic                 drv_wr_valid,
    input  wire logic [35:0]          drv_wr_data,
    output logic                      drv_wr_ready,
    // Observed write traffic
    output logic [3:0]                wr_count,
    output logic [35:0]               wr_last
);
    logic [3:0]  rd_left;
    logic [35:0] noise;
    // Read codes, write checks too, source eight words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_left  <= 4'h0;
            noise    <= 36'h0;
            wr_count <= 4'h0;
            wr_last  <= 36'h0;
        end
        else
        begin
            noise <= noise + 36'h1;
            if (drv_cmd.go && src_en && drv_cmd.fn inside {6'h39, 6'h3B, 6'h29, 6'h2B})
                rd_left <= 4'h8;
            else if (drv_rd_valid && drv_rd_ready)
                rd_left <= rd_left - 4'h1;
            if (drv_wr_valid && drv_wr_ready)
            begin
                wr_count <= wr_count + 4'h1;
                wr_last  <= drv_wr_data;
            end
        end
    end
    // Stall one cycle in four; idle data changes every cycle
    assign drv_wr_ready = noise[1:0] != 2'h3;
    assign drv_rd_valid = rd_left != 4'h0;
    assign drv_rd_data  = drv_rd_valid ? {32'h5A5A_5A5A, rd_left} : noise;
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_defines.svh"
// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module testbench;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, mem_ack = 1'b0, busy, done, end_of_block_pulse, e;
    logic        drv_rd_valid, drv_rd_ready, drv_wr_valid, drv_wr_ready, src_en = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [35:0] mem_rdata = 36'h0, drv_rd_data, drv_wr_data, wr_last;
    logic [35:0] mem [256];
    logic [5:0]  function_indicator, go_fn;
    logic [3:0]  wr_count;
    logic [2:0]  go_sel;
    int          bad_count = 0, cmp_count = 0, go_count = 0, eob_count = 0;
    dbt_pkg::dbt_mem_req_s mem_req;
    dbt_pkg::dbt_drv_cmd_s drv_cmd;
    logic [5:0]  codes [17] = '{6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0B, 6'h0D, 6'h0F,
                                6'h11, 6'h13, 6'h19, 6'h29, 6'h2B, 6'h31, 6'h33, 6'h39, 6'h3B};

    dbt_sequencer dut (.drive_sclk(1'b0), .drv_block_end(1'b0), .drv_disk_end(1'b0), .*);
    dbt_drive_model drive (.*);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Core memory answering each request one cycle later
    always @(posedge pclk)
    begin
        mem_ack <= mem_req.req && !mem_ack;
        if (mem_req.req && !mem_ack)
        begin
            mem_rdata <= mem[mem_req.addr[7:0]];
            if (mem_req.we)
                mem[mem_req.addr[7:0]] <= mem_req.wdata;
        end
    end
    // Record drive command and end of block pulses
    always @(posedge pclk)
    begin
        if (drv_cmd.go === 1'b1)
        begin
            go_count++;
            go_fn = drv_cmd.fn;
            go_sel = drv_cmd.sel;
        end
        if (end_of_block_pulse === 1'b1)
            eob_count++;
    end

    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, {4'h0, exp}, {4'h0, q});
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 5000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("done", 36'h1, {35'h0, done});
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        mem = '{default: 36'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("status", `DBT_STAT_OFS, 32'h0);
        rdc("cmd", `DBT_CMD_OFS, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 36'h1, {35'h0, e});
        for (int i = 0; i < 17; i++)
        begin
            apb(1'b1, `DBT_CMD_OFS, {22'h0, i[2:0], 1'b1, codes[i]});
            chk("indicator", {30'h0, codes[i]}, {30'h0, function_indicator});
            chk("go fn", {30'h0, codes[i]}, {30'h0, go_fn});
            chk("go sel", {33'h0, i[2:0]}, {33'h0, go_sel});
        end
        chk("go count", 36'd17, 36'(go_count));
        // Read function filled from two halves per word
        mem[64] = 36'h0_0000_0080;
        mem[128] = {18'h3FFFE, 18'h000BF};
        apb(1'b1, `DBT_INITIAL_CONTROL_WORD_ADDRESS_OFS, 32'h40);
        apb(1'b1, `DBT_CMD_OFS, 32'h3079);
        for (int i = 0; i < 4; i++)
            apb(1'b1, `DBT_DB_OFS, i == 3 ? 32'h7FFFF : 32'h3FFFF);
        wait_done();
        chk("word 0", 36'hF_FFFF_FFFF, mem[192]);
        chk("word 1", 36'hF_FFFF_FFFF, mem[193]);
        chk("term", {18'h00081, 18'h000C1}, mem[65]);
        rdc("term left", `DBT_TERML_OFS, 32'h81);
        rdc("term right", `DBT_TERMR_OFS, 32'hC1);
        apb(1'b1, `DBT_CMD_OFS, 32'h45);
        chk("eob", 36'h1, 36'(eob_count));
        // Write of eight words to the drive
        mem[128] = {18'h3FFF8, 18'h000BF};
        for (int i = 0; i < 8; i++)
            mem[192 + i] = 36'h1_0000_0000 + 36'(i);
        apb(1'b1, `DBT_CMD_OFS, 32'h3071);
        wait_done();
        chk("drive words", 36'h8, {32'h0, wr_count});
        chk("drive last", 36'h1_0000_0007, wr_last);
        chk("term", {18'h00081, 18'h000C7}, mem[65]);
        // Write check reads eight words from the drive
        src_en <= 1'b1;
        apb(1'b1, `DBT_CMD_OFS, 32'h3069);
        wait_done();
        for (int i = 0; i < 8; i++)
            chk("read word", {32'h5A5A_5A5A, 4'(8 - i)}, mem[192 + i]);
        chk("term", {18'h00081, 18'h000C7}, mem[65]);
        end_of_test();
    end
endmodule
`default_nettype wire
